// ==== core/aoe_angle_output_encoders.sv ====
`timescale 1ns/1ns
// Functional notes
// - Shadow registers rewritable; hardware reset discards them.
// - Fuse memory programs once, survives reset.
// - Unprogrammed registers read zero and work.
// - Zero position from high byte and low six.
// - Low-register bits 6,7 gate field faults.
// - Index width: 0 gives 3 LSB, 1 gives 1.
// - Settings bit 4 disables dynamic compensation.
// - Settings bit 6 selects angle at 3FFF.
// - Output select: quadrature+W or UVW+index.
// - Settings bit 7 enables pulse-width output.
// - Pole-pair code 0..6 means 1..7, 7 means 7.
// - Resolution bit: 11 or 10 bit quadrature.
// - Hysteresis table depends on resolution.
// - Commutation ignores quadrature resolution.
// - A leads when angle rises; direction inverts.
// - Quadrature outputs high during power-on.
// - Commutation outputs low during power-on.
// - Commutation from 14-bit angle and pole pairs.
// - Frame 12 init, 4 check, 4095 data, 8 low.
// - Data at 12-bit, period 444 ns.
// - Error frame shows only init periods high.
// - Repair field forces one map bit high.
// - Access is command frame plus data frame.
// - Error safe state: quadrature all high.
// - Error safe state: commutation all low.
module aoe_angle_output_encoders #(
  parameter int PWM_DIV = aoe_pkg::PWM_DIV
) (
  input  wire logic                sys_clk,        // System clock.
  input  wire logic                sys_rst,        // Hardware reset, synchronous.
  input  wire logic                pwr_on_rst,     // Supply-up clear of fuse model.
  input  wire aoe_pkg::aoe_req_t   req,            // Decoded register access.
  output logic [15:0]              rdata_q,        // Read data of last read.
  input  wire logic [13:0]         angle_comp,     // Compensated angle.
  input  wire logic [13:0]         angle_raw,      // Uncompensated angle.
  input  wire aoe_pkg::aoe_diag_t  diag,           // Diagnostic flags.
  input  wire logic                otp_burn,       // Burn pulse.
  input  wire logic                otp_refresh,    // Reload shadows from fuses.
  output logic                     otp_programmed, // Fuses already burnt.
  output logic                     error_flag,     // Outputs in safe state.
  output logic                     comp_disable,   // Compensation off to front end.
  output logic                     noise_profile,  // Noise setting to front end.
  output aoe_pkg::aoe_pins_t       pins_q          // Encoder pins.
);

  aoe_pkg::aoe_cfg_t shadow_q;
  aoe_pkg::aoe_cfg_t otp_q;
  aoe_pkg::aoe_cfg_t cfg;
  logic              otp_done_q;

  logic [13:0] zero_pos;
  logic [13:0] angle_out;
  logic [13:0] angle_rel;
  logic [13:0] angle_dir;
  logic        power_on;
  logic        fault;
  logic        out_sel;
  logic        pwm_en;
  logic        res10;
  logic [2:0]  pole_pairs;
  logic [1:0]  hysteresis_width;

  logic [10:0] pos;
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [11:0] delta;
  logic [10:0] cnt_last;
  logic        index_hit;

  logic [16:0] elec_prod;
  logic [16:0] sect_prod;
  logic [2:0]  sector;
  logic [2:0]  uvw;
  logic        pwm_q;

  aoe_pkg::aoe_pins_t pins_d;

  // Hysteresis in LSBs of the active resolution.
  function automatic logic [1:0] hys_lsb(input logic is10, input logic [1:0] code);
    if (is10) begin
      hys_lsb = 2'd2 - code;
    end else begin
      hys_lsb = 2'd3 - code;
    end
  endfunction

  // Hall pattern {u,v,w} for each sixth of an electrical turn.
  function automatic logic [2:0] hall(input logic [2:0] sec);
    unique case (sec)
      3'd0:    hall = 3'b100;
      3'd1:    hall = 3'b110;
      3'd2:    hall = 3'b010;
      3'd3:    hall = 3'b011;
      3'd4:    hall = 3'b001;
      3'd5:    hall = 3'b101;
      default: hall = 3'b000;
    endcase
  endfunction

  // Shadow registers: written freely, reloaded from the fuses on reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || otp_refresh) begin
      shadow_q <= otp_q;
    end else if (req.wr) begin
      unique case (req.addr)
        aoe_pkg::ADDR_ZERO_HIGH:  shadow_q.zh <= req.wdata[7:0];
        aoe_pkg::ADDR_ZERO_LOW:   shadow_q.zl <= req.wdata[7:0];
        aoe_pkg::ADDR_SETTINGS_1: shadow_q.s1 <= req.wdata[7:0];
        aoe_pkg::ADDR_SETTINGS_2: shadow_q.s2 <= req.wdata[7:0];
        aoe_pkg::ADDR_REPAIR: begin
          shadow_q.fuse_repair_select <= {3'b000, req.wdata[aoe_pkg::REPAIR_W-1:0]};
        end
        default: ;
      endcase
    end
  end

  // Fuse model: only the supply-up clear reaches it, so a hardware reset keeps it.
  always_ff @(posedge sys_clk) begin
    if (pwr_on_rst) begin
      otp_q      <= '0;
      otp_done_q <= 1'b0;
    end else if (otp_burn && !otp_done_q) begin
      otp_q      <= shadow_q;
      otp_done_q <= 1'b1;
    end
  end

  assign otp_programmed = otp_done_q;

  // Repair code n forces bit n of the first four registers; code 0 repairs nothing.
  always_comb begin
    logic [31:0] flat;
    flat = {shadow_q.s2, shadow_q.s1, shadow_q.zl, shadow_q.zh};
    if (shadow_q.fuse_repair_select[aoe_pkg::REPAIR_W-1:0] != 5'h00) begin
      flat[shadow_q.fuse_repair_select[aoe_pkg::REPAIR_W-1:0]] = 1'b1;
    end
    cfg = {shadow_q.fuse_repair_select, flat};
  end

  assign zero_pos      = {cfg.zh, cfg.zl[aoe_pkg::ZL_POS_MSB:0]};
  assign comp_disable  = cfg.s1[aoe_pkg::S1_COMP_DIS_BIT];
  assign noise_profile = cfg.s1[aoe_pkg::S1_NOISE_BIT];
  assign out_sel       = cfg.s1[aoe_pkg::S1_OUT_SEL_BIT];
  assign pwm_en        = cfg.s1[aoe_pkg::S1_PWM_EN_BIT];
  assign res10         = cfg.s2[aoe_pkg::S2_RES_BIT];
  assign hysteresis_width           = hys_lsb(res10, cfg.s2[aoe_pkg::S2_HYS_LSB+:2]);

  always_comb begin
    logic [2:0] code;
    code = cfg.s2[aoe_pkg::S2_POLE_LSB+:3];
    if (code == 3'd7) begin
      pole_pairs = 3'd7;
    end else begin
      pole_pairs = code + 3'd1;
    end
  end

  assign power_on = !diag.loops_done;

  always_comb begin
    fault = diag.overflow;
    if (cfg.zl[aoe_pkg::ZL_STRONG_EN_BIT] && diag.too_strong) begin
      fault = 1'b1;
    end
    if (cfg.zl[aoe_pkg::ZL_WEAK_EN_BIT] && diag.too_weak) begin
      fault = 1'b1;
    end
  end

  assign error_flag = fault;

  // Dynamic compensation off means the outputs follow the raw angle.
  assign angle_out = comp_disable ? angle_raw : angle_comp;
  assign angle_rel = angle_out - zero_pos;
  assign angle_dir = cfg.s1[aoe_pkg::S1_DIR_BIT] ? 14'(-angle_rel) : angle_rel;

  // Quadrature tracker: follows the angle one step per cycle beyond the hysteresis.
  assign pos      = res10 ? {1'b0, angle_dir[13:4]} : angle_dir[13:3];
  assign cnt_last = res10 ? 11'h3FF : 11'h7FF;

  always_comb begin
    logic [10:0] d11;
    d11   = pos - cnt_q;
    delta = res10 ? {{2{d11[9]}}, d11[9:0]} : {d11[10], d11};
  end

  always_comb begin
    cnt_d = cnt_q;
    if (power_on) begin
      cnt_d = pos;
    end else if ($signed(delta) > $signed({10'h000, hysteresis_width})) begin
      cnt_d = (cnt_q + 11'd1) & cnt_last;
    end else if ($signed(delta) < -$signed({10'h000, hysteresis_width})) begin
      cnt_d = (cnt_q - 11'd1) & cnt_last;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 11'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    if (cfg.s1[aoe_pkg::S1_INDEX_WIDTH_BIT]) begin
      index_hit = (cnt_q == 11'h000);
    end else begin
      index_hit = (cnt_q == 11'h000) || (cnt_q == 11'h001) || (cnt_q == cnt_last);
    end
  end

  // Commutation uses the full 14-bit angle, independent of the quadrature setting.
  assign elec_prod = {3'b000, angle_dir} * {14'h0000, pole_pairs};
  assign sect_prod = {3'b000, elec_prod[13:0]} * 17'd6;
  assign sector    = sect_prod[16:14];
  assign uvw       = hall(sector);

  aoe_pwm_frame #(
    .DIV (PWM_DIV)
  ) u_pwm (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .enable  (pwm_en),
    .error   (fault || power_on),
    .angle   (angle_dir[13:2]),
    .pwm_q   (pwm_q)
  );

  // Pin routing and safe states.
  always_comb begin
    pins_d = '0;
    if (!out_sel) begin
      if (power_on) begin
        {pins_d.a, pins_d.b, pins_d.idx} = 3'b111;
      end else if (fault) begin
        {pins_d.a, pins_d.b, pins_d.idx} = 3'b111;
      end else begin
        pins_d.a   = cnt_q[1] ^ cnt_q[0];
        pins_d.b   = cnt_q[1];
        pins_d.idx = index_hit;
      end
      pins_d.w = pwm_en && pwm_q;
    end else begin
      if (power_on) begin
        {pins_d.u, pins_d.v, pins_d.w} = 3'b000;
      end else if (fault) begin
        {pins_d.u, pins_d.v, pins_d.w} = 3'b000;
      end else begin
        {pins_d.u, pins_d.v, pins_d.w} = uvw;
      end
      pins_d.idx = pwm_en && pwm_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pins_q <= '{a: 1'b1, b: 1'b1, idx: 1'b1, u: 1'b0, v: 1'b0, w: 1'b0};
    end else begin
      pins_q <= pins_d;
    end
  end

  // Read data stands until the next read; unmapped addresses read zero.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        aoe_pkg::ADDR_ZERO_HIGH:  rdata_q <= {8'h00, shadow_q.zh};
        aoe_pkg::ADDR_ZERO_LOW:   rdata_q <= {8'h00, shadow_q.zl};
        aoe_pkg::ADDR_SETTINGS_1: rdata_q <= {8'h00, shadow_q.s1};
        aoe_pkg::ADDR_SETTINGS_2: rdata_q <= {8'h00, shadow_q.s2};
        aoe_pkg::ADDR_REPAIR:     rdata_q <= {8'h00, shadow_q.fuse_repair_select};
        aoe_pkg::ADDR_ANGLE_SEL: begin
          rdata_q <= {2'b00, cfg.s1[aoe_pkg::S1_DATA_SEL_BIT] ? angle_raw : angle_comp};
        end
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

endmodule

// ==== core/aoe_pkg.sv ====
package aoe_pkg;

  // Shadow and fuse map addresses, then the angle read address.
  localparam logic [13:0] ADDR_ZERO_HIGH  = 14'h0016;
  localparam logic [13:0] ADDR_ZERO_LOW   = 14'h0017;
  localparam logic [13:0] ADDR_SETTINGS_1 = 14'h0018;
  localparam logic [13:0] ADDR_SETTINGS_2 = 14'h0019;
  localparam logic [13:0] ADDR_REPAIR     = 14'h001A;
  localparam logic [13:0] ADDR_ANGLE_SEL  = 14'h3FFF;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions in zero_position_low_and_fault_enables.
  localparam int ZL_POS_MSB       = 5;
  localparam int ZL_STRONG_EN_BIT = 6;
  localparam int ZL_WEAK_EN_BIT   = 7;

  // Field positions in output_settings_first.
  localparam int S1_INDEX_WIDTH_BIT = 0;
  localparam int S1_NOISE_BIT       = 1;
  localparam int S1_DIR_BIT         = 2;
  localparam int S1_OUT_SEL_BIT     = 3;
  localparam int S1_COMP_DIS_BIT    = 4;
  localparam int S1_DATA_SEL_BIT    = 6;
  localparam int S1_PWM_EN_BIT      = 7;

  // Field positions in output_settings_second.
  localparam int S2_POLE_LSB = 0;
  localparam int S2_HYS_LSB  = 3;
  localparam int S2_RES_BIT  = 5;

  localparam int REPAIR_W = 5;

  // Pulse-width frame, in pulse-width clock periods.
  localparam int PWM_INIT   = 12;
  localparam int PWM_ERRDET = 4;
  localparam int PWM_DATA   = 4095;
  localparam int PWM_TAIL   = 8;
  localparam int PWM_FRAME  = 4119;

  localparam int CLK_PERIOD_NS = 4;
  localparam int PWM_PERIOD_NS = 444;
  localparam int PWM_DIV       = PWM_PERIOD_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } aoe_req_t;

  typedef struct packed {
    logic loops_done;
    logic overflow;
    logic too_strong;
    logic too_weak;
  } aoe_diag_t;

  typedef struct packed {
    logic a;
    logic b;
    logic idx;
    logic u;
    logic v;
    logic w;
  } aoe_pins_t;

  typedef struct packed {
    logic [7:0] fuse_repair_select;
    logic [7:0] s2;
    logic [7:0] s1;
    logic [7:0] zl;
    logic [7:0] zh;
  } aoe_cfg_t;

endpackage

// ==== core/aoe_pwm_frame.sv ====
`timescale 1ns/1ns
// Frame: init high, error-detect field, angle high time, then low to the end.
module aoe_pwm_frame #(
  parameter int DIV = aoe_pkg::PWM_DIV
) (
  input  wire logic        sys_clk,  // System clock.
  input  wire logic        sys_rst,  // Synchronous reset, active high.
  input  wire logic        enable,   // Pulse-width output enabled.
  input  wire logic        error,    // Diagnostic error or power-on.
  input  wire logic [11:0] angle,    // Angle at 12-bit resolution.
  output logic             pwm_q     // Encoded output.
);

  localparam logic [12:0] INIT_END = 13'(aoe_pkg::PWM_INIT);
  localparam logic [12:0] ERR_END  = 13'(aoe_pkg::PWM_INIT + aoe_pkg::PWM_ERRDET);
  localparam logic [12:0] LAST     = 13'(aoe_pkg::PWM_FRAME - 1);

  logic [15:0] div_q;
  logic [12:0] per_q;
  logic [11:0] ang_q;
  logic        err_q;
  logic        tick;
  logic        level;

  assign tick = (div_q == 16'(DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Angle and error are caught at frame start so one frame never mixes two values.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable) begin
      per_q <= 13'h0000;
      ang_q <= 12'h000;
      err_q <= 1'b1;
    end else if (tick) begin
      if (per_q == LAST) begin
        per_q <= 13'h0000;
        ang_q <= angle;
        err_q <= error;
      end else begin
        per_q <= per_q + 13'h0001;
      end
    end
  end

  always_comb begin
    if (per_q < INIT_END) begin
      level = 1'b1;
    end else if (per_q < ERR_END) begin
      level = !err_q;
    end else begin
      level = !err_q && ((per_q - ERR_END) < {1'b0, ang_q});
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !enable) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= level;
    end
  end

endmodule

// ==== tb/aoe_properties.sv ====
`timescale 1ns/1ns
module aoe_properties #(
  parameter int PWM_DIV = aoe_pkg::PWM_DIV
) (
  input wire logic               sys_clk,        // Clock.
  input wire logic               sys_rst,        // Reset.
  input wire logic               pwr_on_rst,     // Fuse clear.
  input wire aoe_pkg::aoe_req_t  req,            // Access.
  input wire logic [15:0]        rdata_q,        // Read data.
  input wire aoe_pkg::aoe_diag_t diag,           // Flags.
  input wire logic               otp_burn,       // Burn.
  input wire logic               otp_refresh,    // Reload.
  input wire logic               otp_programmed, // Burnt.
  input wire logic               error_flag,     // Fault.
  input wire aoe_pkg::aoe_pins_t pins_q          // Pins.
);
  logic [13:0] wa_q;
  logic [7:0]  wd_q;
  logic        quiet;
  logic        mapped;

  always_ff @(posedge sys_clk) begin
    if (req.wr) begin
      wa_q <= req.addr;
      wd_q <= req.wdata[7:0];
    end
  end

  // A config change or a fault may move both quadrature bits at once, so those cycles are excluded.
  assign quiet = diag.loops_done && !error_flag && !req.wr && !otp_refresh;
  assign mapped = (req.addr >= aoe_pkg::ADDR_ZERO_HIGH && req.addr <= aoe_pkg::ADDR_REPAIR)
                  || req.addr == aoe_pkg::ADDR_ANGLE_SEL;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // The host leaves one idle cycle between a write and the read that follows it.
  sequence s_wr_rd;
    req.wr && !otp_refresh ##1 !req.wr && !otp_refresh
    ##1 req.rd && req.addr == wa_q && wa_q >= aoe_pkg::ADDR_ZERO_HIGH && wa_q <= aoe_pkg::ADDR_SETTINGS_2;
  endsequence
  sequence s_fault;
    error_flag || !diag.loops_done;
  endsequence

  property p_readback;
    s_wr_rd |=> rdata_q == {8'h00, wd_q};
  endproperty
  property p_unmapped;
    req.rd && !mapped |=> rdata_q == 16'h0000;
  endproperty
  property p_hold;
    !req.rd |=> $stable(rdata_q);
  endproperty
  property p_overflow;
    diag.overflow |-> error_flag;
  endproperty
  property p_safe_quad;
    s_fault |=> (pins_q.a && pins_q.b && pins_q.idx && !pins_q.u && !pins_q.v)
                || {pins_q.a, pins_q.b, pins_q.u, pins_q.v, pins_q.w} == 5'b00000;
  endproperty
  property p_safe_uvw;
    s_fault |=> !pins_q.u && !pins_q.v;
  endproperty
  property p_otp_keep;
    otp_programmed && !pwr_on_rst |=> otp_programmed;
  endproperty
  property p_burn;
    otp_burn && !otp_programmed |-> ##[1:2] otp_programmed;
  endproperty
  property p_gray;
    quiet [*3] |=> $countones({pins_q.a, pins_q.b} ^ $past({pins_q.a, pins_q.b})) <= 1;
  endproperty

  a_readback: assert property (p_readback) else $error("readback differs from last write");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_overflow: assert property (p_overflow) else $error("overflow without error flag");
  a_safe_quad: assert property (p_safe_quad) else $error("quadrature not in safe state");
  a_safe_uvw: assert property (p_safe_uvw) else $error("commutation not in safe state");
  a_otp_keep: assert property (p_otp_keep) else $error("programmed flag lost");
  a_burn: assert property (p_burn) else $error("burn did not program");
  a_gray: assert property (p_gray) else $error("quadrature jumped two states");
endmodule

bind aoe_angle_output_encoders aoe_properties #(.PWM_DIV(PWM_DIV)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst), .req(req), .rdata_q(rdata_q),
  .diag(diag), .otp_burn(otp_burn), .otp_refresh(otp_refresh), .otp_programmed(otp_programmed),
  .error_flag(error_flag), .pins_q(pins_q)
);

// ==== tb/aoe_host.sv ====
`timescale 1ns/1ns
module aoe_host (
  input  wire logic         sys_clk, // Clock.
  input  wire logic [15:0]  rdata_q, // Read data.
  input  wire logic         pwm_pin, // Pulse-width pin.
  output aoe_pkg::aoe_req_t req      // Access to device.
);
  initial req = '0;

  // One strobe stands for a whole command frame plus its data frame.
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    #1 req = '0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1 req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk);
    #1 req = '0;
    d = rdata_q;
  endtask

  // A frame under way, or the first one after enable, is skipped before measuring.
  task automatic frame(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (!pwm_pin) @(posedge sys_clk) #1;
    while (pwm_pin) @(posedge sys_clk) #1;
    while (!pwm_pin) @(posedge sys_clk) #1;
    while (pwm_pin) @(posedge sys_clk) #1 hi++;
    while (!pwm_pin) @(posedge sys_clk) #1 lo++;
  endtask
endmodule

// ==== tb/aoe_angle_output_encoders_test.sv ====
`timescale 1ns/1ns
module aoe_angle_output_encoders_test;
  localparam int DIV = 2;
  localparam logic [14:0] QX = {3'b001, 3'b101, 3'b110, 3'b010, 3'b000};
  localparam logic [17:0] PAT = {3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101};
  logic               sys_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               pwr_on_rst = 1'b1;
  logic [13:0]        angle_comp = 14'h0000;
  logic [13:0]        angle_raw = 14'h0000;
  aoe_pkg::aoe_diag_t diag = 4'b1000;
  logic               otp_burn = 1'b0;
  logic               otp_refresh = 1'b0;
  aoe_pkg::aoe_req_t  req;
  aoe_pkg::aoe_pins_t pins_q;
  logic [15:0]        rdata_q;
  logic [15:0]        d;
  logic               otp_programmed;
  logic               error_flag;
  logic               comp_disable;
  logic               noise_profile;
  int                 fails = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  int                 hi;
  int                 lo;

  always #2 sys_clk = ~sys_clk;

  aoe_angle_output_encoders #(.PWM_DIV(DIV)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst), .req(req), .rdata_q(rdata_q),
    .angle_comp(angle_comp), .angle_raw(angle_raw), .diag(diag), .otp_burn(otp_burn),
    .otp_refresh(otp_refresh), .otp_programmed(otp_programmed), .error_flag(error_flag),
    .comp_disable(comp_disable), .noise_profile(noise_profile), .pins_q(pins_q)
  );
  aoe_host host (.sys_clk(sys_clk), .rdata_q(rdata_q), .pwm_pin(pins_q.w), .req(req));

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rchk(input logic [13:0] a, input logic [15:0] exp);
    host.rd(a, d);
    chk("rdata_q", exp, d);
  endtask

  task automatic abi(input logic [13:0] ang, input logic [2:0] exp);
    angle_comp = ang;
    wait_n(12);
    chk("abi", {13'h0, exp}, {13'h0, pins_q.a, pins_q.b, pins_q.idx});
  endtask

  function automatic logic [2:0] uvw_exp(input int ang, input int code);
    int pp;
    int s;
    pp = (code == 7) ? 7 : code + 1;
    s = ((ang * pp) % 16384) * 6 / 16384;
    return PAT[17 - 3 * s -: 3];
  endfunction

  initial begin
    wait_n(20);
    sys_rst = 1'b0;
    pwr_on_rst = 1'b0;
    for (int i = 0; i < 5; i++) rchk(aoe_pkg::ADDR_ZERO_HIGH + 14'(i), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      host.wr(aoe_pkg::ADDR_ZERO_HIGH + 14'(i), 16'h12A5);
      rchk(aoe_pkg::ADDR_ZERO_HIGH + 14'(i), 16'h00A5);
    end
    host.wr(aoe_pkg::ADDR_REPAIR, 16'h00FF);
    rchk(aoe_pkg::ADDR_REPAIR, 16'h001F);
    rchk(14'h0020, 16'h0000);
    sys_rst = 1'b1;
    wait_n(1);
    sys_rst = 1'b0;
    rchk(aoe_pkg::ADDR_SETTINGS_1, 16'h0000);
    angle_comp = 14'h1234;
    angle_raw = 14'h0ABC;
    rchk(aoe_pkg::ADDR_ANGLE_SEL, 16'h1234);
    chk("comp_disable", 16'h0000, {15'h0, comp_disable});
    chk("noise_profile", 16'h0000, {15'h0, noise_profile});
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0052);
    rchk(aoe_pkg::ADDR_ANGLE_SEL, 16'h0ABC);
    chk("comp_disable", 16'h0001, {15'h0, comp_disable});
    chk("noise_profile", 16'h0001, {15'h0, noise_profile});
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      diag.too_strong = (j == 0);
      diag.too_weak = (j == 1);
      host.wr(aoe_pkg::ADDR_ZERO_LOW, 16'h0000);
      wait_n(1);
      chk("error_flag", 16'h0000, {15'h0, error_flag});
      host.wr(aoe_pkg::ADDR_ZERO_LOW, 16'h0040 << j);
      wait_n(2);
      chk("error_flag", 16'h0001, {15'h0, error_flag});
      chk("abi", 16'h0007, {13'h0, pins_q.a, pins_q.b, pins_q.idx});
    end
    host.wr(aoe_pkg::ADDR_ZERO_LOW, 16'h0000);
    diag = 4'b0000;
    wait_n(2);
    chk("abi", 16'h0007, {13'h0, pins_q.a, pins_q.b, pins_q.idx});
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0008);
    wait_n(2);
    chk("uvw", 16'h0000, {13'h0, pins_q.u, pins_q.v, pins_q.w});
    diag = 4'b1100;
    wait_n(2);
    chk("error_flag", 16'h0001, {15'h0, error_flag});
    chk("uvw", 16'h0000, {13'h0, pins_q.u, pins_q.v, pins_q.w});
    diag = 4'b1000;
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0088);
    wait_n(3);
    chk("pwm_on_idx", 16'h0001, {15'h0, pins_q.idx});
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0008);
    angle_comp = 14'd3640;
    for (int c = 0; c < 8; c++) begin
      host.wr(aoe_pkg::ADDR_SETTINGS_2, {10'h0, c[0], 2'b00, 3'(c)});
      wait_n(2);
      chk("uvw", {13'h0, uvw_exp(3640, c)}, {13'h0, pins_q.u, pins_q.v, pins_q.w});
    end
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0000);
    host.wr(aoe_pkg::ADDR_SETTINGS_2, 16'h0018);
    // The tracker walks one step a cycle, so a power-on interval snaps it to the new angle.
    angle_comp = 14'd0;
    diag = 4'b0000;
    wait_n(2);
    diag = 4'b1000;
    abi(14'd0, 3'b001);
    for (int k = 0; k < 5; k++) abi(14'(8 * k), QX[14 - 3 * k -: 3]);
    abi(14'd0, 3'b001);
    host.wr(aoe_pkg::ADDR_SETTINGS_2, 16'h0000);
    abi(14'd24, 3'b001);
    abi(14'd0, 3'b001);
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0001);
    host.wr(aoe_pkg::ADDR_SETTINGS_2, 16'h0030);
    abi(14'd16, 3'b100);
    abi(14'd8, 3'b001);
    host.wr(aoe_pkg::ADDR_SETTINGS_2, 16'h0018);
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0004);
    abi(14'd8, 3'b011);
    host.wr(aoe_pkg::ADDR_SETTINGS_1, 16'h0080);
    angle_comp = 14'h0100;
    host.frame(hi, lo);
    chk("pwm_high", 16'(80 * DIV), 16'(hi));
    chk("pwm_low", 16'(4039 * DIV), 16'(lo));
    diag.overflow = 1'b1;
    host.frame(hi, lo);
    chk("pwm_high", 16'(12 * DIV), 16'(hi));
    chk("pwm_low", 16'(4107 * DIV), 16'(lo));
    diag.overflow = 1'b0;
    host.wr(aoe_pkg::ADDR_ZERO_HIGH, 16'h005A);
    otp_burn = 1'b1;
    wait_n(1);
    otp_burn = 1'b0;
    wait_n(3);
    chk("otp_programmed", 16'h0001, {15'h0, otp_programmed});
    sys_rst = 1'b1;
    wait_n(1);
    sys_rst = 1'b0;
    rchk(aoe_pkg::ADDR_ZERO_HIGH, 16'h005A);
    host.wr(aoe_pkg::ADDR_ZERO_HIGH, 16'h0000);
    otp_burn = 1'b1;
    wait_n(1);
    otp_burn = 1'b0;
    otp_refresh = 1'b1;
    wait_n(1);
    otp_refresh = 1'b0;
    rchk(aoe_pkg::ADDR_ZERO_HIGH, 16'h005A);
    end_of_test();
  end
endmodule
